// *** core/fault_alert_pkg.sv ***
// shared constants and carrier types for the fault/alert mask and status block
package fault_alert_pkg;
    // command codes of the four registers
    localparam logic [7:0] ALERT_MASK_ADDR   = 8'hF9;
    localparam logic [7:0] FAULT_MASK_ADDR   = 8'hFA;
    localparam logic [7:0] SUMMARY_ADDR      = 8'hFB;
    localparam logic [7:0] PHASE_STAT_ADDR   = 8'hFC;
    // reset values
    localparam logic [7:0] ALERT_MASK_RESET  = 8'h00;
    localparam logic [7:0] FAULT_MASK_RESET  = 8'h00;
    localparam logic [7:0] SUMMARY_RESET     = 8'h00;
    localparam logic [7:0] PHASE_STAT_RESET  = 8'h00;
    // implemented mask bits: 7 6 3 2 0 (alert), 7 6 3 0 (+2 kept for fault)
    localparam logic [7:0] ALERT_MASK_WMASK  = 8'hCD;
    localparam logic [7:0] FAULT_MASK_WMASK  = 8'hCD;
    // mask bit positions
    localparam int unsigned MASK_VOLT_BIT    = 7;
    localparam int unsigned MASK_CURR_BIT    = 6;
    localparam int unsigned MASK_COMM_BIT    = 3;
    localparam int unsigned MASK_MON_BIT     = 2;
    localparam int unsigned MASK_POWER_BIT   = 0;
    // summary status bit positions
    localparam int unsigned SUM_FAULT_BIT    = 7;
    localparam int unsigned SUM_ALERT_BIT    = 6;
    localparam int unsigned SUM_PGOOD_BIT    = 5;
    localparam int unsigned SUM_READY_BIT    = 4;
    // phase status bit positions
    localparam int unsigned PH4_BIT          = 5;
    localparam int unsigned PH3_BIT          = 4;
    localparam int unsigned PH2_BIT          = 3;
    localparam int unsigned POWER_SAVE_BIT   = 2;

    // pending event requests, one per source, for alert or fault
    typedef struct packed {
        logic output_voltage;
        logic output_current;
        logic comm_logic_status;
        logic monitored_voltage;
        logic output_power;
    } event_set_t;

    // register access port of the command interface
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage : fault_alert_pkg

// *** core/fault_alert_mask_status.sv ***
// event masking, summary flags and status registers of the regulator command set
`timescale 1ns/1ps

module fault_alert_mask_status (
    // clock and reset
    input  wire logic                           clock_i,
    input  wire logic                           reset_i,
    // register access from the serial command front end
    input  wire fault_alert_pkg::reg_req_t      req_i,
    output logic [7:0]                          rdata_o,
    output logic                                rvalid_o,
    // event sources
    input  wire fault_alert_pkg::event_set_t    alert_src_i,
    input  wire fault_alert_pkg::event_set_t    fault_src_i,
    // device state
    input  wire logic                           power_good_i,
    input  wire logic                           ready_i,
    input  wire logic [2:0]                     phase_en_i,
    input  wire logic                           power_save_indicator_i,
    // summary indications
    output logic                                alert_o,
    output logic                                fault_o
);

    logic [7:0] alert_mask_r;
    logic [7:0] fault_mask_r;
    logic [7:0] summary_r;
    logic [7:0] phase_stat_r;
    logic       alert_nxt;
    logic       fault_nxt;
    logic [7:0] summary_nxt;
    logic [7:0] phase_stat_nxt;
    logic [7:0] rdata_nxt;

    // mask registers; only implemented bits store so reserved bits stay zero
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            alert_mask_r <= fault_alert_pkg::ALERT_MASK_RESET;
        end else if (req_i.wr && req_i.addr == fault_alert_pkg::ALERT_MASK_ADDR) begin
            alert_mask_r <= req_i.wdata & fault_alert_pkg::ALERT_MASK_WMASK;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            fault_mask_r <= fault_alert_pkg::FAULT_MASK_RESET;
        end else if (req_i.wr && req_i.addr == fault_alert_pkg::FAULT_MASK_ADDR) begin
            fault_mask_r <= req_i.wdata & fault_alert_pkg::FAULT_MASK_WMASK;
        end
    end

    // gated alert: any unmasked source raises it
    always_comb begin
        alert_nxt =
            (alert_src_i.output_voltage    & ~alert_mask_r[fault_alert_pkg::MASK_VOLT_BIT])  |
            (alert_src_i.output_current    & ~alert_mask_r[fault_alert_pkg::MASK_CURR_BIT])  |
            (alert_src_i.comm_logic_status & ~alert_mask_r[fault_alert_pkg::MASK_COMM_BIT])  |
            (alert_src_i.monitored_voltage & ~alert_mask_r[fault_alert_pkg::MASK_MON_BIT])   |
            (alert_src_i.output_power      & ~alert_mask_r[fault_alert_pkg::MASK_POWER_BIT]);
    end

    // gated fault; bit 2 also gates the monitored-voltage path, the field is printed
    // in both masks and leaving it ungated would make a stored bit meaningless
    always_comb begin
        fault_nxt =
            (fault_src_i.output_voltage    & ~fault_mask_r[fault_alert_pkg::MASK_VOLT_BIT])  |
            (fault_src_i.output_current    & ~fault_mask_r[fault_alert_pkg::MASK_CURR_BIT])  |
            (fault_src_i.comm_logic_status & ~fault_mask_r[fault_alert_pkg::MASK_COMM_BIT])  |
            (fault_src_i.monitored_voltage & ~fault_mask_r[fault_alert_pkg::MASK_MON_BIT])   |
            (fault_src_i.output_power      & ~fault_mask_r[fault_alert_pkg::MASK_POWER_BIT]);
    end

    // status snapshots, registered so a read sees one coherent byte
    always_comb begin
        summary_nxt = 8'h00;
        summary_nxt[fault_alert_pkg::SUM_FAULT_BIT] = fault_nxt;
        summary_nxt[fault_alert_pkg::SUM_ALERT_BIT] = alert_nxt;
        summary_nxt[fault_alert_pkg::SUM_PGOOD_BIT] = power_good_i;
        summary_nxt[fault_alert_pkg::SUM_READY_BIT] = ready_i;
    end

    always_comb begin
        phase_stat_nxt = 8'h00;
        phase_stat_nxt[fault_alert_pkg::PH4_BIT] = phase_en_i[2];
        phase_stat_nxt[fault_alert_pkg::PH3_BIT] = phase_en_i[1];
        phase_stat_nxt[fault_alert_pkg::PH2_BIT] = phase_en_i[0];
        phase_stat_nxt[fault_alert_pkg::POWER_SAVE_BIT] = power_save_indicator_i;
    end

    // status registers have no write path at all
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            summary_r    <= fault_alert_pkg::SUMMARY_RESET;
            phase_stat_r <= fault_alert_pkg::PHASE_STAT_RESET;
        end else begin
            summary_r    <= summary_nxt;
            phase_stat_r <= phase_stat_nxt;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            alert_o <= 1'b0;
            fault_o <= 1'b0;
        end else begin
            alert_o <= alert_nxt;
            fault_o <= fault_nxt;
        end
    end

    // read mux; unmapped codes answer zero
    always_comb begin
        case (req_i.addr)
            fault_alert_pkg::ALERT_MASK_ADDR: rdata_nxt = alert_mask_r;
            fault_alert_pkg::FAULT_MASK_ADDR: rdata_nxt = fault_mask_r;
            fault_alert_pkg::SUMMARY_ADDR:    rdata_nxt = summary_r;
            fault_alert_pkg::PHASE_STAT_ADDR: rdata_nxt = phase_stat_r;
            default:                          rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) begin
                rdata_o <= rdata_nxt;
            end
        end
    end

    // checks; masked cases use one source alone so another path cannot hide a leak
    volt_alert_mask_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (alert_mask_r[7] && alert_src_i == 5'h10) |=> !alert_o)
        else $error("masked output-voltage alert escaped");

    curr_alert_mask_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (alert_mask_r[6] && alert_src_i == 5'h08) |=> !alert_o)
        else $error("masked output-current alert escaped");

    comm_alert_mask_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (alert_mask_r[3] && alert_src_i == 5'h04) |=> !alert_o)
        else $error("masked comm alert escaped");

    mon_alert_mask_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (alert_mask_r[2] && alert_src_i == 5'h02) |=> !alert_o)
        else $error("masked monitored-voltage alert escaped");

    power_alert_mask_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (alert_mask_r[0] && alert_src_i == 5'h01) |=> !alert_o)
        else $error("masked output-power alert escaped");

    // an unmasked source must always get through
    volt_alert_pass_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (!alert_mask_r[7] && alert_src_i.output_voltage) |=> alert_o)
        else $error("unmasked output-voltage alert lost");

    curr_alert_pass_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (!alert_mask_r[6] && alert_src_i.output_current) |=> alert_o)
        else $error("unmasked output-current alert lost");

    comm_alert_pass_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (!alert_mask_r[3] && alert_src_i.comm_logic_status) |=> alert_o)
        else $error("unmasked comm alert lost");

    mon_alert_pass_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (!alert_mask_r[2] && alert_src_i.monitored_voltage) |=> alert_o)
        else $error("unmasked monitored-voltage alert lost");

    power_alert_pass_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (!alert_mask_r[0] && alert_src_i.output_power) |=> alert_o)
        else $error("unmasked output-power alert lost");

    quiet_alert_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (alert_src_i == 5'h00) |=> !alert_o)
        else $error("alert with no source");

    volt_fault_mask_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (fault_mask_r[7] && fault_src_i == 5'h10) |=> !fault_o)
        else $error("masked output-voltage fault escaped");

    curr_fault_mask_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (fault_mask_r[6] && fault_src_i == 5'h08) |=> !fault_o)
        else $error("masked output-current fault escaped");

    comm_fault_mask_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (fault_mask_r[3] && fault_src_i == 5'h04) |=> !fault_o)
        else $error("masked comm fault escaped");

    mon_fault_mask_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (fault_mask_r[2] && fault_src_i == 5'h02) |=> !fault_o)
        else $error("masked monitored-voltage fault escaped");

    power_fault_mask_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (fault_mask_r[0] && fault_src_i == 5'h01) |=> !fault_o)
        else $error("masked output-power fault escaped");

    volt_fault_pass_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (!fault_mask_r[7] && fault_src_i.output_voltage) |=> fault_o)
        else $error("unmasked output-voltage fault lost");

    curr_fault_pass_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (!fault_mask_r[6] && fault_src_i.output_current) |=> fault_o)
        else $error("unmasked output-current fault lost");

    comm_fault_pass_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (!fault_mask_r[3] && fault_src_i.comm_logic_status) |=> fault_o)
        else $error("unmasked comm fault lost");

    mon_fault_pass_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (!fault_mask_r[2] && fault_src_i.monitored_voltage) |=> fault_o)
        else $error("unmasked monitored-voltage fault lost");

    power_fault_pass_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (!fault_mask_r[0] && fault_src_i.output_power) |=> fault_o)
        else $error("unmasked output-power fault lost");

    quiet_fault_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (fault_src_i == 5'h00) |=> !fault_o)
        else $error("fault with no source");

    // status snapshots lag the live inputs by one cycle
    pgood_mirror_a: assert property (@(posedge clock_i) disable iff (reset_i)
        ##1 summary_r[5] == $past(power_good_i))
        else $error("power good bit wrong");

    ready_bit_a: assert property (@(posedge clock_i) disable iff (reset_i)
        ##1 summary_r[4] == $past(ready_i))
        else $error("ready bit wrong");

    summary_flags_a: assert property (@(posedge clock_i) disable iff (reset_i)
        ##1 summary_r[7] == fault_o && summary_r[6] == alert_o)
        else $error("summary flags disagree with outputs");

    summary_spare_a: assert property (@(posedge clock_i) disable iff (reset_i)
        summary_r[3:0] == 4'h0)
        else $error("unused summary bit set");

    phase_bits_a: assert property (@(posedge clock_i) disable iff (reset_i)
        ##1 phase_stat_r[5:3] == $past(phase_en_i))
        else $error("phase enable bits wrong");

    power_save_bit_a: assert property (@(posedge clock_i) disable iff (reset_i)
        ##1 phase_stat_r[2] == $past(power_save_indicator_i))
        else $error("power-save bit wrong");

    phase_spare_a: assert property (@(posedge clock_i) disable iff (reset_i)
        phase_stat_r[7:6] == 2'h0 && phase_stat_r[1:0] == 2'h0)
        else $error("unused phase status bit set");

    reserved_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (alert_mask_r & 8'h32) == 8'h00 && (fault_mask_r & 8'h32) == 8'h00)
        else $error("reserved mask bit set");

    // register access
    alert_mask_write_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (req_i.wr && req_i.addr == fault_alert_pkg::ALERT_MASK_ADDR)
        |=> alert_mask_r == ($past(req_i.wdata) & fault_alert_pkg::ALERT_MASK_WMASK))
        else $error("alert mask write lost");

    fault_mask_write_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (req_i.wr && req_i.addr == fault_alert_pkg::FAULT_MASK_ADDR)
        |=> fault_mask_r == ($past(req_i.wdata) & fault_alert_pkg::FAULT_MASK_WMASK))
        else $error("fault mask write lost");

    alert_mask_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
        !(req_i.wr && req_i.addr == fault_alert_pkg::ALERT_MASK_ADDR)
        |=> $stable(alert_mask_r))
        else $error("alert mask changed without a write");

    fault_mask_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
        !(req_i.wr && req_i.addr == fault_alert_pkg::FAULT_MASK_ADDR)
        |=> $stable(fault_mask_r))
        else $error("fault mask changed without a write");

    read_valid_a: assert property (@(posedge clock_i) disable iff (reset_i)
        ##1 rvalid_o == $past(req_i.rd))
        else $error("read valid does not follow the strobe");

    read_alert_mask_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (req_i.rd && req_i.addr == fault_alert_pkg::ALERT_MASK_ADDR)
        |=> rdata_o == $past(alert_mask_r))
        else $error("alert mask read wrong");

    read_fault_mask_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (req_i.rd && req_i.addr == fault_alert_pkg::FAULT_MASK_ADDR)
        |=> rdata_o == $past(fault_mask_r))
        else $error("fault mask read wrong");

    read_summary_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (req_i.rd && req_i.addr == fault_alert_pkg::SUMMARY_ADDR)
        |=> rdata_o == $past(summary_r))
        else $error("summary read wrong");

    read_phase_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (req_i.rd && req_i.addr == fault_alert_pkg::PHASE_STAT_ADDR)
        |=> rdata_o == $past(phase_stat_r))
        else $error("phase status read wrong");

    read_unmapped_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (req_i.rd && req_i.addr < fault_alert_pkg::ALERT_MASK_ADDR)
        |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");

endmodule // fault_alert_mask_status

// *** dv/cmd_host_model.sv ***
// host-side model that issues single-byte register commands to the block
`timescale 1ns/1ps
module cmd_host_model (
    // clock
    input  wire logic                        clock_i,
    // register access
    output fault_alert_pkg::reg_req_t        req_o,
    input  wire logic [7:0]                  rdata_i,
    input  wire logic                        rvalid_i
);
    initial req_o = '0;

    // one strobe per byte; released lines carry the inverse so stale values never look valid
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic ok);
        @(posedge clock_i);
        req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clock_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        q = 8'h00;
        ok = w;
        #1;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rvalid_i === 1'b1) begin
                q = rdata_i;
                ok = 1'b1;
            end else begin
                @(posedge clock_i);
                #1;
            end
        end
    endtask
endmodule // cmd_host_model

// *** dv/fault_alert_mask_status_test.sv ***
// self-checking bench for the fault/alert mask and status block
`timescale 1ns/1ps
module fault_alert_mask_status_test;
    logic                          clock_i    = 1'b0;
    logic                          reset_i    = 1'b1;
    fault_alert_pkg::reg_req_t     req;
    fault_alert_pkg::event_set_t   alert_src  = '0;
    fault_alert_pkg::event_set_t   fault_src  = '0;
    logic                          power_good = 1'b0;
    logic                          ready      = 1'b0;
    logic [2:0]                    phase_en   = 3'h0;
    logic                          power_save = 1'b0;
    logic [7:0]                    rdata;
    logic                          rvalid;
    logic                          alert;
    logic                          fault;
    int                            fails      = 0;
    int                            checks     = 0;

    always #5 clock_i = ~clock_i;

    fault_alert_mask_status i_fault_alert_mask_status (.clock_i(clock_i), .reset_i(reset_i),
        .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .alert_src_i(alert_src),
        .fault_src_i(fault_src), .power_good_i(power_good), .ready_i(ready),
        .phase_en_i(phase_en), .power_save_indicator_i(power_save), .alert_o(alert),
        .fault_o(fault));
    cmd_host_model i_cmd_host_model (.clock_i(clock_i), .req_o(req), .rdata_i(rdata),
        .rvalid_i(rvalid));

    task automatic results;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       ok;
        i_cmd_host_model.access(1'b1, a, d, q, ok);
    endtask

    // a read that never answers ends the run at once
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic       ok;
        i_cmd_host_model.access(1'b0, a, 8'h00, q, ok);
        if (!ok) begin
            fails++;
            results();
        end
        check(q, exp);
    endtask

    task automatic settle;
        repeat (3) @(posedge clock_i);
        #1;
    endtask

    task automatic mask_access;
        reg_rd(8'hF9, 8'h00);
        reg_rd(8'hFA, 8'h00);
        reg_wr(8'hF9, 8'hFF);
        reg_wr(8'hFA, 8'h32);
        reg_wr(8'hFB, 8'hFF);
        reg_wr(8'hFC, 8'hFF);
        reg_rd(8'hF9, 8'hCD);
        reg_rd(8'hFA, 8'h00);
        reg_rd(8'hFB, 8'h00);
        reg_rd(8'hFC, 8'h00);
        reg_rd(8'h5A, 8'h00);
        reg_wr(8'hF9, 8'h00);
    endtask

    // each source alone: raised with other masks set, silenced by its own mask bit
    task automatic event_gating;
        int         pos[5] = '{0, 2, 3, 6, 7};
        logic [7:0] m;
        for (int f = 0; f < 2; f++) begin
            for (int k = 0; k < 5; k++) begin
                m = 8'h01 << pos[k];
                @(posedge clock_i);
                if (f == 0) begin
                    alert_src <= 5'h01 << k;
                end else begin
                    fault_src <= 5'h01 << k;
                end
                settle();
                check({6'h00, alert, fault}, f ? 8'h01 : 8'h02);
                reg_rd(8'hFB, f ? 8'h80 : 8'h40);
                reg_wr(f ? 8'hFA : 8'hF9, 8'hCD & ~m);
                settle();
                check({6'h00, alert, fault}, f ? 8'h01 : 8'h02);
                reg_wr(f ? 8'hFA : 8'hF9, m);
                settle();
                check({6'h00, alert, fault}, 8'h00);
                reg_rd(8'hFB, 8'h00);
                reg_wr(f ? 8'hFA : 8'hF9, 8'h00);
                @(posedge clock_i);
                alert_src <= '0;
                fault_src <= '0;
            end
        end
    endtask

    task automatic status_bits;
        for (int v = 0; v < 16; v++) begin
            @(posedge clock_i);
            phase_en <= v[2:0];
            power_save <= v[3];
            power_good <= v[0];
            ready <= v[1];
            settle();
            reg_rd(8'hFC, {2'b00, v[2:0], v[3], 2'b00});
            reg_rd(8'hFB, {2'b00, v[0], v[1], 4'h0});
        end
    endtask

    initial begin
        repeat (16) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        mask_access();
        event_gating();
        status_bits();
        results();
    end
endmodule // fault_alert_mask_status_test
